// ===== rtl/stc_pkg.sv
package stc_pkg;

    // register indices on the plain register port
    localparam logic [2:0] STC_ADDR_CTRL = 3'h0;
    localparam logic [2:0] STC_ADDR_CNT_LO = 3'h1;
    localparam logic [2:0] STC_ADDR_CNT_HI = 3'h2;
    localparam logic [2:0] STC_ADDR_INT_STATUS = 3'h3;
    localparam logic [2:0] STC_ADDR_INT_MASK = 3'h4;

    localparam int STC_ADDR_W = 3;
    localparam int STC_DATA_W = 8;
    localparam int STC_PRE_W = 3;

    localparam logic [7:0] STC_CTRL_RESET = 8'h00;
    localparam logic [7:0] STC_BYTE_ZERO = 8'h00;
    localparam logic [15:0] STC_COUNT_RESET = 16'h0000;
    localparam logic [15:0] STC_COUNT_ONE = 16'h0001;
    localparam logic [15:0] STC_COUNT_MAX = 16'hFFFF;
    localparam logic [2:0] STC_PRE_ZERO = 3'h0;
    localparam logic [2:0] STC_PRE_ONE = 3'h1;
    localparam logic [1:0] STC_DIV_ZERO = 2'h0;
    localparam logic [1:0] STC_DIV_ONE = 2'h1;

    // interrupt status / mask layout
    localparam int STC_INT_OVF_BIT = 0;
    localparam logic [7:0] STC_INT_USED = 8'h01;

    // clock: 50 MHz, instruction clock is the oscillator divided by four
    localparam int STC_CLK_PERIOD_NS = 20;
    localparam int STC_INSTR_DIV = 4;

    // bits 7:6 unimplemented, read as zero
    typedef struct packed {
        logic [1:0] unused;
        logic [1:0] prescale;
        logic crystal_osc_enable;
        logic sync_bypass;
        logic clock_source_select;
        logic run_control;
    } stc_ctrl_t;

    typedef struct packed {
        logic [STC_ADDR_W-1:0] addr;
        logic [STC_DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } stc_bus_req_t;

    typedef enum logic [1:0] {
        STC_SRC_INTERNAL = 2'b00,
        STC_SRC_EXT_SYNC = 2'b01,
        STC_SRC_EXT_ASYNC = 2'b10
    } stc_src_t;

endpackage

// ===== rtl/stc_timer16.sv
// Operation
// - source select: 0 instruction clock, 1 external
// - run bit enables or halts counting
// - internal mode ignores the sync bit
// - external source counts on rising edges only
// - one falling edge required before counting
// - osc enable picks crystal pin, else clock pin
// - sync after ripple prescaler when bit clear
// - sync mode in sleep: prescaler only counts
// - async mode counts in sleep, overflow wakes
// - async mode not a capture/compare time base
// - byte reads always return stable values
// - sync bit: 1 bypass, 0 synchronize
// - osc enable runs or shuts off inverter
// - writing either count byte clears prescaler
// - control resets to zero on power-on only
//
// Added by the designer: the strobed register port and the register addresses.
module stc_timer16
    import stc_pkg::*;
#(
    parameter int INSTR_DIV = STC_INSTR_DIV
)
(
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic warm_rst_in,
    input wire logic [STC_ADDR_W-1:0] reg_addr_in,
    input wire logic [STC_DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [STC_DATA_W-1:0] reg_rdata_out,
    input wire logic external_count_pin_in,
    input wire logic crystal_input_pin_in,
    input wire logic sleep_in,
    output logic crystal_osc_drive_out,
    output logic timebase_valid_out,
    output logic irq_out,
    output logic wake_out
);

    function automatic logic [STC_PRE_W-1:0] pre_mask(input logic [1:0] ps);
        pre_mask = STC_PRE_W'((1 << ps) - 1);
    endfunction

    localparam logic [1:0] DIV_LAST = 2'(INSTR_DIV - 1);

    stc_bus_req_t req;
    stc_ctrl_t ctrl_ff;
    stc_src_t src;
    logic [15:0] count_ff;
    logic [STC_PRE_W-1:0] pre_ff;
    logic [1:0] div_ff;
    logic pin_q_ff;
    logic pin_prev_ff;
    logic armed_ff;
    logic sync1_ff;
    logic sync2_ff;
    logic [7:0] int_status_ff;
    logic [7:0] int_mask_ff;
    logic instr_en;
    logic sel_pin;
    logic pin_rise;
    logic pin_fall;
    logic ext_edge;
    logic pre_in;
    logic pre_tick;
    logic cnt_tick;
    logic cnt_inc;
    logic wr_cnt;
    logic ovf_event;
    logic status_rd;

    assign req = '{addr: reg_addr_in, wdata: reg_wdata_in, wr: reg_wr_in, rd: reg_rd_in};
    assign wr_cnt = req.wr && (req.addr == STC_ADDR_CNT_LO || req.addr == STC_ADDR_CNT_HI);
    assign status_rd = req.rd && req.addr == STC_ADDR_INT_STATUS;

    always_comb
    begin
        if (!ctrl_ff.clock_source_select)
            src = STC_SRC_INTERNAL;
        else if (ctrl_ff.sync_bypass)
            src = STC_SRC_EXT_ASYNC;
        else
            src = STC_SRC_EXT_SYNC;
    end

    // control register: only the power-on reset clears it
    always_ff @(posedge ref_clk_in)
    begin
        if (sys_rst_in)
            ctrl_ff <= stc_ctrl_t'(STC_CTRL_RESET);
        else if (req.wr && req.addr == STC_ADDR_CTRL)
        begin
            ctrl_ff <= stc_ctrl_t'(req.wdata);
            ctrl_ff.unused <= 2'b00;
        end
    end

    assign crystal_osc_drive_out = ctrl_ff.crystal_osc_enable;

    // instruction clock enable; the oscillator stops in sleep
    always_ff @(posedge ref_clk_in)
    begin
        if (sys_rst_in || warm_rst_in)
            div_ff <= STC_DIV_ZERO;
        else if (!sleep_in)
            div_ff <= (div_ff == DIV_LAST) ? STC_DIV_ZERO : div_ff + STC_DIV_ONE;
    end

    assign instr_en = !sleep_in && div_ff == DIV_LAST;

    // pins are synchronous, one flop gives the edge history
    assign sel_pin = ctrl_ff.crystal_osc_enable ? crystal_input_pin_in
                                                : external_count_pin_in;

    always_ff @(posedge ref_clk_in)
    begin
        if (sys_rst_in)
        begin
            pin_q_ff <= 1'b0;
            pin_prev_ff <= 1'b0;
        end
        else
        begin
            pin_q_ff <= sel_pin;
            pin_prev_ff <= pin_q_ff;
        end
    end

    assign pin_rise = pin_q_ff && !pin_prev_ff;
    assign pin_fall = !pin_q_ff && pin_prev_ff;

    // a high input at enable must not look like a first rising edge
    always_ff @(posedge ref_clk_in)
    begin
        if (sys_rst_in || warm_rst_in)
            armed_ff <= 1'b0;
        else if (!ctrl_ff.run_control || !ctrl_ff.clock_source_select)
            armed_ff <= 1'b0;
        else if (pin_fall)
            armed_ff <= 1'b1;
    end

    assign ext_edge = armed_ff && pin_rise;
    assign pre_in = ctrl_ff.run_control &&
                    ((src == STC_SRC_INTERNAL) ? instr_en : ext_edge);
    assign pre_tick = pre_in && (pre_ff & pre_mask(ctrl_ff.prescale)) ==
                                pre_mask(ctrl_ff.prescale);

    // prescaler keeps running in sleep for external edges
    always_ff @(posedge ref_clk_in)
    begin
        if (sys_rst_in || warm_rst_in || wr_cnt)
            pre_ff <= STC_PRE_ZERO;
        else if (pre_in)
            pre_ff <= pre_ff + STC_PRE_ONE;
    end

    // two-stage synchroniser after the prescaler; it keeps running in sleep, but its output is ignored there
    always_ff @(posedge ref_clk_in)
    begin
        if (sys_rst_in || warm_rst_in)
        begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
        end
        else
        begin
            sync1_ff <= pre_tick && src == STC_SRC_EXT_SYNC;
            sync2_ff <= sync1_ff;
        end
    end

    always_comb
    begin
        case (src)
            STC_SRC_INTERNAL: cnt_tick = pre_tick;
            STC_SRC_EXT_SYNC: cnt_tick = sync2_ff && !sleep_in;
            STC_SRC_EXT_ASYNC: cnt_tick = pre_tick;
            default: cnt_tick = 1'b0;
        endcase
    end

    // a count byte write wins over an increment in the same cycle
    assign cnt_inc = cnt_tick && ctrl_ff.run_control && !wr_cnt;
    assign ovf_event = cnt_inc && count_ff == STC_COUNT_MAX;

    always_ff @(posedge ref_clk_in)
    begin
        if (sys_rst_in)
            count_ff <= STC_COUNT_RESET;
        else if (req.wr && req.addr == STC_ADDR_CNT_LO)
            count_ff[7:0] <= req.wdata;
        else if (req.wr && req.addr == STC_ADDR_CNT_HI)
            count_ff[15:8] <= req.wdata;
        else if (cnt_inc)
            count_ff <= count_ff + STC_COUNT_ONE;
    end

    // sticky status, cleared by reading it; a new overflow wins
    always_ff @(posedge ref_clk_in)
    begin
        if (sys_rst_in || warm_rst_in)
            int_status_ff <= STC_BYTE_ZERO;
        else if (ovf_event)
            int_status_ff[STC_INT_OVF_BIT] <= 1'b1;
        else if (status_rd)
            int_status_ff <= STC_BYTE_ZERO;
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (sys_rst_in || warm_rst_in)
            int_mask_ff <= STC_BYTE_ZERO;
        else if (req.wr && req.addr == STC_ADDR_INT_MASK)
            int_mask_ff <= req.wdata & STC_INT_USED;
    end

    assign irq_out = |(int_status_ff & int_mask_ff);
    assign wake_out = irq_out && sleep_in;
    assign timebase_valid_out = ctrl_ff.run_control && src != STC_SRC_EXT_ASYNC;

    // count lives in this clock domain, so a byte read is never torn
    always_ff @(posedge ref_clk_in)
    begin
        if (sys_rst_in)
            reg_rdata_out <= STC_BYTE_ZERO;
        else if (req.rd)
        begin
            case (req.addr)
                STC_ADDR_CTRL: reg_rdata_out <= ctrl_ff;
                STC_ADDR_CNT_LO: reg_rdata_out <= count_ff[7:0];
                STC_ADDR_CNT_HI: reg_rdata_out <= count_ff[15:8];
                STC_ADDR_INT_STATUS: reg_rdata_out <= int_status_ff;
                STC_ADDR_INT_MASK: reg_rdata_out <= int_mask_ff;
                default: reg_rdata_out <= STC_BYTE_ZERO;
            endcase
        end
        else
            reg_rdata_out <= STC_BYTE_ZERO;
    end

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);

    chk_instr_rate: assert property (
        instr_en ##1 (!sleep_in && !warm_rst_in)[*4] |-> instr_en)
        else $error("instruction enable not every fourth cycle");
    chk_run_halt: assert property (
        !ctrl_ff.run_control && !req.wr |=> $stable(count_ff))
        else $error("counter moved while halted");
    chk_sync_ignored: assert property (
        !ctrl_ff.clock_source_select && ctrl_ff.run_control |-> pre_in == instr_en)
        else $error("internal mode not driven by instruction clock");
    chk_rise_only: assert property (
        pre_in && ctrl_ff.clock_source_select |-> pin_q_ff && !pin_prev_ff)
        else $error("external count without rising edge");
    // arming is dropped while halted, so the first edge after run is never counted
    chk_arm_fall: assert property (
        $rose(ctrl_ff.run_control) |-> !armed_ff)
        else $error("counting armed at run enable");
    chk_arm_source: assert property (
        $rose(armed_ff) |-> $past(pin_fall))
        else $error("counting armed without a falling edge");
    chk_pin_select: assert property (
        ctrl_ff.crystal_osc_enable && $stable(ctrl_ff) |-> ##1 pin_q_ff == $past(crystal_input_pin_in))
        else $error("crystal pin not selected");
    chk_sync_delay: assert property (
        pre_tick && src == STC_SRC_EXT_SYNC |-> ##2 sync2_ff)
        else $error("synchronised tick not two cycles late");
    chk_sleep_stall: assert property (
        sleep_in && src == STC_SRC_EXT_SYNC && !wr_cnt |=> $stable(count_ff))
        else $error("sync counter moved in sleep");
    chk_async_sleep: assert property (
        sleep_in && src == STC_SRC_EXT_ASYNC && pre_tick && !wr_cnt |=>
            count_ff == $past(count_ff) + STC_COUNT_ONE)
        else $error("async counter stalled in sleep");
    chk_no_timebase: assert property (
        ctrl_ff.clock_source_select && ctrl_ff.sync_bypass |-> !timebase_valid_out)
        else $error("async mode offered as time base");
    chk_prescale_clear: assert property (
        wr_cnt |=> pre_ff == STC_PRE_ZERO)
        else $error("prescaler not cleared by count write");
    chk_ctrl_reset: assert property (
        $past(sys_rst_in) |-> ctrl_ff == stc_ctrl_t'(STC_CTRL_RESET))
        else $error("control not zero after power-on reset");
    chk_overflow_wrap: assert property (
        ovf_event |=> count_ff == STC_COUNT_RESET && int_status_ff[STC_INT_OVF_BIT])
        else $error("overflow did not wrap and flag");
    chk_status_clear: assert property (
        status_rd && !ovf_event |=> int_status_ff == STC_BYTE_ZERO)
        else $error("status not cleared by its read");

    cov_async_wake: cover property (src == STC_SRC_EXT_ASYNC && sleep_in && ovf_event);
    cov_sync_count: cover property (src == STC_SRC_EXT_SYNC && cnt_inc);
    cov_internal_ovf: cover property (src == STC_SRC_INTERNAL && ovf_event);
    cov_irq_read: cover property (irq_out ##1 status_rd);
    cov_sleep_stall: cover property (src == STC_SRC_EXT_SYNC && sleep_in && sync2_ff);

endmodule

// ===== testbench/stc_clk_src.sv
module stc_clk_src (
    input wire logic clk_in,
    output logic ext_pin_out,
    output logic xtal_pin_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // both pins rest low between bursts, as a stopped source would
    initial
    begin
        ext_pin_out = 1'b0;
        xtal_pin_out = 1'b0;
    end

    // each level held three clocks, above the one-clock minimum
    task automatic burst(input logic xtal, input int n);
        for (int i = 0; i < 2 * n; i++)
        begin
            @(posedge clk_in);
            if (xtal)
                xtal_pin_out <= ~xtal_pin_out;
            else
                ext_pin_out <= ~ext_pin_out;
            repeat (2) @(posedge clk_in);
        end
    endtask
endmodule

// ===== testbench/tb.sv
module tb
    import stc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {logic [7:0] lo; logic [7:0] hi;} stc_note_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic warm = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic slp = 1'b0;
    logic rd_q = 1'b0;
    logic [STC_ADDR_W-1:0] addr = '0;
    logic [STC_DATA_W-1:0] wdata = '0;
    logic [STC_DATA_W-1:0] rdata;
    logic ext_pin, xtal_pin, osc_drv, tb_valid, irq, wake;
    logic [7:0] cfgs[9] = '{8'h01, 8'h05, 8'h07, 8'h0F, 8'h03, 8'h0B, 8'h17, 8'h27, 8'h37};
    int fails = 0;
    int n_checks = 0;
    int n;
    stc_note_t notes[$];

    always #10 clk = ~clk;

    stc_timer16 u_stc_timer16 (
        .ref_clk_in(clk), .sys_rst_in(rst), .warm_rst_in(warm),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdata), .external_count_pin_in(ext_pin),
        .crystal_input_pin_in(xtal_pin), .sleep_in(slp),
        .crystal_osc_drive_out(osc_drv), .timebase_valid_out(tb_valid),
        .irq_out(irq), .wake_out(wake)
    );

    stc_clk_src u_stc_clk_src (.clk_in(clk), .ext_pin_out(ext_pin), .xtal_pin_out(xtal_pin));

    task automatic finish_test();
        if (fails == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk8(stc_note_t e);
        n_checks++;
        if (((rdata >= e.lo) && (rdata <= e.hi)) !== 1'b1)
        begin
            fails++;
            $display("FAIL rdata exp %h..%h got %h", e.lo, e.hi, rdata);
        end
    endtask

    task automatic chk1(string s, logic e, logic g);
        n_checks++;
        if (g !== e)
        begin
            fails++;
            $display("FAIL %s exp %b got %b", s, e, g);
        end
    endtask

    always @(posedge clk) rd_q <= rd;
    always @(negedge clk)
        if (rd_q)
            chk8(notes.pop_front());

    task automatic wr8(logic [STC_ADDR_W-1:0] a, logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd8(logic [STC_ADDR_W-1:0] a, logic [7:0] lo, logic [7:0] hi);
        notes.push_back('{lo, hi});
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
    endtask

    // counter stopped before its bytes are written, then primed with one pulse
    task automatic cfg(logic [7:0] c);
        wr8(STC_ADDR_CTRL, 8'h00);
        wr8(STC_ADDR_CNT_LO, 8'h00);
        wr8(STC_ADDR_CNT_HI, 8'h00);
        wr8(STC_ADDR_CTRL, c);
        u_stc_clk_src.burst(c[3], 1);
    endtask

    task automatic pulses(logic [7:0] c, int k, logic [15:0] e);
        u_stc_clk_src.burst(!c[3], 2);
        u_stc_clk_src.burst(c[3], k);
        repeat (6) @(posedge clk);
        rd8(STC_ADDR_CNT_HI, e[15:8], e[15:8]);
        rd8(STC_ADDR_CNT_LO, e[7:0], e[7:0]);
        rd8(STC_ADDR_CNT_HI, e[15:8], e[15:8]);
    endtask

    initial
    begin
        repeat (100000) @(posedge clk);
        fails++;
        $display("FAIL watchdog exp done got hang");
        finish_test();
    end

    initial
    begin
        void'($urandom(79));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 6; a++)
            rd8(a[2:0], 8'h00, 8'h00);
        @(negedge clk);
        chk1("irq", 1'b0, irq);
        chk1("osc", 1'b0, osc_drv);
        wr8(STC_ADDR_CTRL, 8'hFF);
        rd8(STC_ADDR_CTRL, 8'h3F, 8'h3F);
        @(negedge clk);
        chk1("osc", 1'b1, osc_drv);
        for (int i = 0; i < 2; i++)
        begin
            cfg(cfgs[i]);
            @(negedge clk);
            chk1("timebase", 1'b1, tb_valid);
            u_stc_clk_src.burst(1'b0, 66);
            wr8(STC_ADDR_CTRL, 8'h00);
            rd8(STC_ADDR_CNT_HI, 8'h00, 8'h00);
            rd8(STC_ADDR_CNT_LO, 8'd98, 8'd102);
        end
        for (int i = 2; i < 9; i++)
        begin
            n = $urandom_range(20, 1);
            cfg(cfgs[i]);
            @(negedge clk);
            chk1("timebase", !cfgs[i][2], tb_valid);
            pulses(cfgs[i], n, 16'(n >> cfgs[i][5:4]));
        end
        cfg(8'h37);
        u_stc_clk_src.burst(1'b0, 5);
        wr8(STC_ADDR_CNT_LO, 8'h00);
        pulses(8'h37, 7, 16'h0000);
        pulses(8'h37, 1, 16'h0001);
        cfg(8'h23);
        slp <= 1'b1;
        // the tick made in sleep is lost, yet the prescaler keeps its edges
        pulses(8'h23, 5, 16'h0000);
        slp <= 1'b0;
        pulses(8'h23, 3, 16'h0001);
        wr8(STC_ADDR_CTRL, 8'h06);
        wr8(STC_ADDR_CNT_LO, 8'hFF);
        wr8(STC_ADDR_CNT_HI, 8'hFF);
        pulses(8'h06, 3, 16'hFFFF);
        slp <= 1'b1;
        wr8(STC_ADDR_CTRL, 8'h07);
        pulses(8'h07, 2, 16'h0000);
        @(negedge clk);
        chk1("irq", 1'b0, irq);
        wr8(STC_ADDR_INT_MASK, 8'h01);
        @(negedge clk);
        chk1("wake", 1'b1, wake);
        chk1("irq", 1'b1, irq);
        rd8(STC_ADDR_INT_STATUS, 8'h01, 8'h01);
        @(negedge clk);
        chk1("irq", 1'b0, irq);
        @(posedge clk);
        slp <= 1'b0;
        u_stc_clk_src.burst(1'b0, 1);
        warm <= 1'b1;
        @(posedge clk);
        warm <= 1'b0;
        rd8(STC_ADDR_CTRL, 8'h07, 8'h07);
        rd8(STC_ADDR_CNT_LO, 8'h01, 8'h01);
        repeat (4) @(posedge clk);
        finish_test();
    end
endmodule
